/* File: rtl/ocm_pkg.sv */
// ocm_pkg: constants, states and lane helpers for the operand data cache
// assumes one 100 MHz core clock and 64-bit cpu and memory data paths
package ocm_pkg;

  localparam int LINES = 512;
  localparam int WAYS = 2;
  localparam int IDX_W = 9;
  localparam int TAG_W = 19;
  localparam int DADDR_W = 11;
  localparam int PA_W = 29;
  localparam int LADDR_W = 24;
  localparam int QADDR_W = 26;
  localparam int CTL_W = 32;

  localparam int CTL_EN_BIT = 0;
  localparam int CTL_WTHRU_BIT = 1;
  localparam int CTL_CPBK_BIT = 2;
  localparam int CTL_INV_BIT = 3;
  localparam int CTL_ENHANCED_CONFIG_SELECT_BIT = 31;
  localparam logic [31:0] CTL_RW_MASK = 32'h8000_0007;
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;

  localparam logic [2:0] EVICT_LAST = 3'h4;
  localparam logic [2:0] BEAT_LAST = 3'h3;

  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;
  localparam logic [1:0] SZ_QUAD = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE, ST_LOOK, ST_EVICT, ST_STORE, ST_FILL, ST_WBACK, ST_UNC
  } ocm_state_e;

  ////////////////////////////////////////////////////////////////////////
  // byte lanes touched by an access of size sz at byte offset off
  function automatic logic [7:0] be_of(input logic [1:0] sz, input logic [2:0] off);
    logic [7:0] m;
    m = 8'hFF;
    if (sz == SZ_BYTE) m = 8'h01;
    else if (sz == SZ_WORD) m = 8'h03;
    else if (sz == SZ_LONG) m = 8'h0F;
    return 8'(m << off);
  endfunction : be_of

  // right-justified store data moved onto its lanes
  function automatic logic [63:0] place_wr(input logic [63:0] d, input logic [2:0] off);
    return 64'(d << {off, 3'h0});
  endfunction : place_wr

  // lanes of a quadword brought down and cut to the access size
  function automatic logic [63:0] align_rd(input logic [63:0] q, input logic [2:0] off,
                                           input logic [1:0] sz);
    logic [63:0] s;
    s = q >> {off, 3'h0};
    if (sz == SZ_BYTE) s = {56'h0, s[7:0]};
    else if (sz == SZ_WORD) s = {48'h0, s[15:0]};
    else if (sz == SZ_LONG) s = {32'h0, s[31:0]};
    return s;
  endfunction : align_rd

endpackage : ocm_pkg

/* File: rtl/ocm_ram_if.sv */
// ocm_ram_if: port of one array (tag or line data) with lane write enables
// assumes the controller drives it every cycle and reads rdata one cycle later
`timescale 1ns/1ps
interface ocm_ram_if #(parameter int AW = 11, parameter int LANES = 8, parameter int LW = 8);
  logic we;
  logic [LANES-1:0] be;
  logic [AW-1:0] addr;
  logic [LANES*LW-1:0] wdata;
  logic [LANES*LW-1:0] rdata;
  modport ctrl (output we, be, addr, wdata, input rdata);
  modport ram (input we, be, addr, wdata, output rdata);
endinterface : ocm_ram_if

/* File: rtl/ocm_ram.sv */
// ocm_ram: single-port array, lane writes, registered read data
// assumes no reset; contents are undefined after power-up
`timescale 1ns/1ps
module ocm_ram #(
  parameter int AW = 11,
  parameter int LANES = 8,
  parameter int LW = 8
) (
  input wire logic i_clock,
  ocm_ram_if.ram mem
);
  logic [LANES*LW-1:0] store [2**AW];

  if (AW < 1 || LANES < 1 || LW < 1) begin : g_bad
    $error("ocm_ram: bad geometry");
  end

  always_ff @(posedge i_clock) begin
    for (int i = 0; i < LANES; i++) begin
      if (mem.we && mem.be[i]) begin
        store[mem.addr][i*LW +: LW] <= mem.wdata[i*LW +: LW];
      end
    end
    mem.rdata <= store[mem.addr];
  end
endmodule : ocm_ram

/* File: rtl/ocm_cache.sv */
// ocm_cache: operand data cache between cpu load/store path and memory bus
// assumes cpu and memory bus logic on the same clock; one request at a time
// How it works
// - compat mode: 512 direct-mapped lines, 19-bit tag, valid, dirty, 32 bytes
// - enhanced mode: two ways of 512 lines each
// - per-set lru bit picks the victim way, hidden from software
// - tag holds pa[28:10]; tags and data never reset
// - power-on reset clears valid and dirty; manual reset keeps them
// - dirty set by copy-back writes only, never under write-through
// - index from ea[13:5], tag compared with pa[28:10]
// - read hit returns the sized data chosen by ea[4:0]
// - clean read miss fills critical word first, returns it early, then valid
// - dirty read miss: buffer victim, fill, then write buffer out
// - copy-back write hit writes the sized bytes into the line
// - copy-back write miss stores first, fills the rest, sets valid and dirty
// - dirty victim on write miss goes to write-back buffer before allocate
// - write-through miss goes to memory only; hit updates line, dirty kept
// - write-back buffer holds one line plus pa[28:5], drained after fill
// - write-through and uncached stores use a 64-bit buffer, cpu freed at once
// - enable bit 0 gates cache use; translated pages need cacheable
// - bit 1 write-through for user regions, bit 2 copy-back privileged, page wins
// - invalidate bit 3 clears all valid and dirty; reads as zero
`timescale 1ns/1ps
module ocm_cache (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_manual_reset,
  input wire logic i_ctrl_wr,
  input wire logic [ocm_pkg::CTL_W-1:0] i_ctrl_wdata,
  output logic [ocm_pkg::CTL_W-1:0] o_ctrl_word,
  input wire logic i_cpu_req,
  input wire logic i_cpu_we,
  input wire logic [1:0] i_cpu_size,
  input wire logic [31:0] i_cpu_ea,
  input wire logic [ocm_pkg::PA_W-1:0] i_cpu_pa,
  input wire logic [63:0] i_cpu_wdata,
  input wire logic i_area_cacheable,
  input wire logic i_priv_region,
  input wire logic i_xlate_on,
  input wire logic i_page_cacheable,
  input wire logic i_page_wthru,
  output logic o_cpu_ready,
  output logic o_cpu_rvalid,
  output logic [63:0] o_cpu_rdata,
  output logic o_mem_req,
  output logic o_mem_we,
  output logic [ocm_pkg::PA_W-1:0] o_mem_addr,
  output logic [7:0] o_mem_be,
  output logic [63:0] o_mem_wdata,
  input wire logic i_mem_ack,
  input wire logic [63:0] i_mem_rdata
);
  import ocm_pkg::*;

  ocm_state_e st_q, st_d;
  logic [2:0] bcnt_q, bcnt_d;
  logic [CTL_W-1:0] ctl_q;
  // one valid and dirty bit per line and way
  logic [LINES-1:0] vld_q [WAYS], dty_q [WAYS];
  logic [LINES-1:0] lru_q;
  logic [IDX_W-1:0] idx_q;
  logic [1:0] qw_q;
  logic [2:0] off_q;
  logic [TAG_W-1:0] ptag_q;
  logic [QADDR_W-1:0] pa_q, wtb_a_q, maddr_q;
  logic wr_q, cach_q, wthru_q, vway_q;
  logic [1:0] size_q;
  logic [7:0] be_q, wtb_be_q, mbe_q;
  logic [63:0] wd_q, wtb_d_q, mdata_q, rdata_q;
  logic [63:0] wbb_q [4];
  logic [LADDR_W-1:0] wbb_addr_q;
  logic wbb_v_q, wtb_v_q, rvalid_q;
  logic mreq_q, mown_q, mwe_q;
  logic [63:0] dat_rd [WAYS];
  logic [TAG_W-1:0] tag_rd [WAYS];
  logic [1:0] dwe, twe;

  default clocking dflt_clk @(posedge i_clock); endclocking
  default disable iff (i_reset);

  ////////////////////////////////////////////////////////////////////////
  // request decode
  wire take = i_cpu_req && o_cpu_ready;
  wire enhanced_config_select = ctl_q[CTL_ENHANCED_CONFIG_SELECT_BIT];
  wire inval = i_ctrl_wr && i_ctrl_wdata[CTL_INV_BIT];
  wire cach_in = ctl_q[CTL_EN_BIT] && i_area_cacheable && (!i_xlate_on || i_page_cacheable);
  wire wthru_in = i_xlate_on ? i_page_wthru :
                  (i_priv_region ? !ctl_q[CTL_CPBK_BIT] : ctl_q[CTL_WTHRU_BIT]);
  wire lk = st_q == ST_LOOK;
  wire mack = mreq_q && i_mem_ack && !mown_q;
  wire wack = mreq_q && i_mem_ack && mown_q;
  wire [1:0] fq = qw_q + bcnt_q[1:0];
  wire hit0 = vld_q[0][idx_q] && tag_rd[0] == ptag_q;
  // second way only in enhanced mode
  wire hit1 = enhanced_config_select && vld_q[1][idx_q] && tag_rd[1] == ptag_q;
  wire hit = hit0 || hit1;
  wire hway = hit1;
  // invalid way first, else least recently used
  wire vway = !enhanced_config_select ? 1'b0 : !vld_q[0][idx_q] ? 1'b0 : !vld_q[1][idx_q] ? 1'b1 : lru_q[idx_q];
  wire vdirty = vld_q[vway][idx_q] && dty_q[vway][idx_q];
  wire wt_path = wr_q && (!cach_q || wthru_q);
  // store lands in the write-through buffer
  wire wtb_push = lk && wt_path && !wtb_v_q;
  wire rd_hit = lk && !wr_q && cach_q && hit;
  wire cb_hit = lk && wr_q && cach_q && !wthru_q && hit;
  // write-through hit updates the line as well as the buffer
  wire wt_hit_wr = wtb_push && cach_q && hit;
  wire miss_go = lk && cach_q && !hit && !(wr_q && wthru_q) && !wtb_v_q;
  // uncached load waits only for older stores
  wire unc_go = lk && !cach_q && !wr_q && !wtb_v_q;
  wire fill_last = st_q == ST_FILL && mack && bcnt_q == BEAT_LAST;
  wire fsm_want = st_q == ST_FILL || st_q == ST_WBACK || st_q == ST_UNC;
  wire launch_f = fsm_want && !mreq_q;
  wire launch_w = !fsm_want && wtb_v_q && !mreq_q;
  wire [QADDR_W-1:0] maddr_f = st_q == ST_FILL ? {pa_q[QADDR_W-1:2], fq} :
                               st_q == ST_WBACK ? {wbb_addr_q, bcnt_q[1:0]} : pa_q;
  wire [7:0] mbe_f = st_q == ST_UNC ? be_q : 8'hFF;
  wire lru_upd = enhanced_config_select && (rd_hit || cb_hit || wt_hit_wr || fill_last);
  wire lru_way = fill_last ? vway_q : hway;
  ////////////////////////////////////////////////////////////////////////
  // array controls
  wire [DADDR_W-1:0] daddr = st_q == ST_IDLE ? i_cpu_ea[13:3] :
                             st_q == ST_EVICT ? {idx_q, bcnt_q[1:0]} :
                             st_q == ST_FILL ? {idx_q, fq} : {idx_q, qw_q};
  wire [IDX_W-1:0] taddr = st_q == ST_IDLE ? i_cpu_ea[13:5] : idx_q;
  // fill skips the bytes already stored
  wire [7:0] dbe = st_q != ST_FILL ? be_q : (wr_q && fq == qw_q) ? ~be_q : 8'hFF;
  wire [63:0] dwd = st_q == ST_FILL ? i_mem_rdata : wd_q;
  // store writes hit or allocated way
  assign dwe[0] = ((cb_hit || wt_hit_wr) && !hway) ||
                  ((st_q == ST_STORE || (st_q == ST_FILL && mack)) && !vway_q);
  assign dwe[1] = ((cb_hit || wt_hit_wr) && hway) ||
                  ((st_q == ST_STORE || (st_q == ST_FILL && mack)) && vway_q);
  // tag written with pa[28:10] at fill end
  assign twe[0] = fill_last && !vway_q;
  assign twe[1] = fill_last && vway_q;

  for (genvar w = 0; w < WAYS; w++) begin : g_way
    ocm_ram_if #(.AW(DADDR_W), .LANES(8), .LW(8)) dif();
    ocm_ram_if #(.AW(IDX_W), .LANES(1), .LW(TAG_W)) tif();
    assign dif.we = dwe[w];
    assign dif.be = dbe;
    assign dif.addr = daddr;
    assign dif.wdata = dwd;
    assign dat_rd[w] = dif.rdata;
    assign tif.we = twe[w];
    assign tif.be = 1'b1;
    assign tif.addr = taddr;
    assign tif.wdata = ptag_q;
    assign tag_rd[w] = tif.rdata;
    ocm_ram #(.AW(DADDR_W), .LANES(8), .LW(8)) u_dat (.i_clock(i_clock), .mem(dif.ram));
    ocm_ram #(.AW(IDX_W), .LANES(1), .LW(TAG_W)) u_tag (.i_clock(i_clock), .mem(tif.ram));
  end
  ////////////////////////////////////////////////////////////////////////
  // sequencer
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE: if (take) st_d = ST_LOOK;
      ST_LOOK: begin
        if (rd_hit || cb_hit || wtb_push) st_d = ST_IDLE;
        else if (unc_go) st_d = ST_UNC;
        // dirty victim is evicted before allocate
        else if (miss_go) st_d = vdirty ? ST_EVICT : (wr_q ? ST_STORE : ST_FILL);
      end
      ST_EVICT: if (bcnt_q == EVICT_LAST) st_d = wr_q ? ST_STORE : ST_FILL;
      ST_STORE: st_d = ST_FILL;
      // buffer drains only after the fill
      ST_FILL: if (fill_last) st_d = wbb_v_q ? ST_WBACK : ST_IDLE;
      ST_WBACK: if (mack && bcnt_q == BEAT_LAST) st_d = ST_IDLE;
      ST_UNC: if (mack) st_d = ST_IDLE;
    endcase
  end
  assign bcnt_d = (st_d != st_q) ? 3'h0 :
                  (st_q == ST_EVICT || mack) ? bcnt_q + 3'h1 : bcnt_q;

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      st_q <= ST_IDLE;
      bcnt_q <= 3'h0;
      ctl_q <= CTL_RESET;
    end else if (i_manual_reset) begin
      st_q <= ST_IDLE;
      bcnt_q <= 3'h0;
      ctl_q <= CTL_RESET;
    end else begin
      st_q <= st_d;
      bcnt_q <= bcnt_d;
      if (i_ctrl_wr) ctl_q <= i_ctrl_wdata & CTL_RW_MASK;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // line state: valid, dirty, lru
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      // power-on reset clears line state; manual reset does not
      vld_q <= '{default: '0};
      dty_q <= '{default: '0};
      lru_q <= '0;
    end else begin
      // invalidate all, a same-cycle fill still lands
      if (inval) begin
        vld_q <= '{default: '0};
        dty_q <= '{default: '0};
      end
      if (fill_last) begin
        vld_q[vway_q][idx_q] <= 1'b1;
        dty_q[vway_q][idx_q] <= wr_q;
      end
      if (cb_hit) dty_q[hway][idx_q] <= 1'b1;
      // remember the way not just used
      if (lru_upd) lru_q[idx_q] <= ~lru_way;
    end
  end

  // request capture
  always_ff @(posedge i_clock) begin
    if (take) begin
      idx_q <= i_cpu_ea[13:5];
      qw_q <= i_cpu_ea[4:3];
      off_q <= i_cpu_ea[2:0];
      ptag_q <= i_cpu_pa[28:10];
      pa_q <= i_cpu_pa[28:3];
      wr_q <= i_cpu_we;
      size_q <= i_cpu_size;
      be_q <= be_of(i_cpu_size, i_cpu_ea[2:0]);
      wd_q <= place_wr(i_cpu_wdata, i_cpu_ea[2:0]);
      cach_q <= cach_in;
      wthru_q <= wthru_in;
    end
    if (lk) vway_q <= vway;
    if (miss_go && vdirty) wbb_addr_q <= {tag_rd[vway], idx_q[4:0]};
    if (st_q == ST_EVICT && bcnt_q != 3'h0) wbb_q[bcnt_q[1:0] - 2'h1] <= dat_rd[vway_q];
  end
  ////////////////////////////////////////////////////////////////////////
  // buffers, memory bus and cpu return
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      wbb_v_q <= 1'b0;
      wtb_v_q <= 1'b0;
      mreq_q <= 1'b0;
      mown_q <= 1'b0;
      rvalid_q <= 1'b0;
    end else if (i_manual_reset) begin
      wbb_v_q <= 1'b0;
      wtb_v_q <= 1'b0;
      mreq_q <= 1'b0;
      mown_q <= 1'b0;
      rvalid_q <= 1'b0;
    end else begin
      if (st_q == ST_WBACK && st_d == ST_IDLE) wbb_v_q <= 1'b0;
      if (miss_go && vdirty) wbb_v_q <= 1'b1;
      if (wack) wtb_v_q <= 1'b0;
      if (wtb_push) wtb_v_q <= 1'b1;
      if (launch_f || launch_w) begin
        mreq_q <= 1'b1;
        mown_q <= launch_w;
      end else if (i_mem_ack) begin
        mreq_q <= 1'b0;
      end
      // critical word returned as it arrives
      rvalid_q <= rd_hit || (st_q == ST_FILL && mack && bcnt_q == 3'h0 && !wr_q) ||
                  (st_q == ST_UNC && mack);
    end
  end

  always_ff @(posedge i_clock) begin
    if (wtb_push) begin
      wtb_a_q <= pa_q;
      wtb_d_q <= wd_q;
      wtb_be_q <= be_q;
    end
    if (launch_f) begin
      mwe_q <= st_q == ST_WBACK;
      maddr_q <= maddr_f;
      mdata_q <= wbb_q[bcnt_q[1:0]];
      mbe_q <= mbe_f;
    end else if (launch_w) begin
      mwe_q <= 1'b1;
      maddr_q <= wtb_a_q;
      mdata_q <= wtb_d_q;
      mbe_q <= wtb_be_q;
    end
    rdata_q <= align_rd(rd_hit ? dat_rd[hway] : i_mem_rdata, off_q, size_q);
  end

  assign o_ctrl_word = ctl_q;
  assign o_cpu_ready = st_q == ST_IDLE;
  assign o_cpu_rvalid = rvalid_q;
  assign o_cpu_rdata = rdata_q;
  assign o_mem_req = mreq_q;
  assign o_mem_we = mwe_q;
  assign o_mem_addr = {maddr_q, 3'h0};
  assign o_mem_be = mbe_q;
  assign o_mem_wdata = mdata_q;
  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_fill_end;
    st_q == ST_FILL && mack && bcnt_q == BEAT_LAST;
  endsequence
  sequence s_evict_run;
    (st_q == ST_EVICT) [*5] ##1 (st_q == ST_STORE || st_q == ST_FILL);
  endsequence

  inval_reads_zero_a: assert property (o_ctrl_word[CTL_INV_BIT] == 1'b0)
    else $error("invalidate bit reads back set");
  disabled_bypass_a: assert property (take && !ctl_q[CTL_EN_BIT] |=> !cach_q)
    else $error("cache used while disabled");
  read_hit_a: assert property (rd_hit |=> o_cpu_rvalid && o_cpu_ready)
    else $error("read hit not answered next cycle");
  fill_critical_a: assert property (launch_f && st_q == ST_FILL && bcnt_q == 3'h0
    |=> o_mem_addr[4:3] == qw_q && !o_mem_we) else $error("fill not critical first");
  wb_after_fill_a: assert property (s_fill_end ##0 wbb_v_q |=> st_q == ST_WBACK)
    else $error("victim not written after fill");
  evict_first_a: assert property (miss_go && vdirty |=> s_evict_run)
    else $error("dirty victim not buffered first");
  wt_release_a: assert property (wtb_push |=> o_cpu_ready && wtb_v_q)
    else $error("store not released at buffer");
  wt_no_dirty_a: assert property (lk && wr_q && wthru_q && !inval
    |=> $stable(dty_q[0]) && $stable(dty_q[1])) else $error("dirty set under write-through");
  compat_way_a: assert property (lk && !enhanced_config_select |-> !hit1 && !vway)
    else $error("second way used in compat mode");
  bypass_quiet_a: assert property (st_q == ST_UNC |-> dwe == 2'h0 && twe == 2'h0)
    else $error("bypass load touched arrays");
  wt_miss_a: assert property (lk && wr_q && wthru_q && cach_q && !hit
    |=> st_q == ST_IDLE || st_q == ST_LOOK) else $error("write-through miss allocated");
endmodule : ocm_cache

/* File: test/ocm_mem_model.sv */
// ocm_mem_model: external memory responder on the cache's memory bus
// assumes quadword beats, one request at a time, acts at the falling edge
`timescale 1ns/1ps
module ocm_mem_model (
  input wire logic i_clock,
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [28:0] i_addr,
  input wire logic [7:0] i_be,
  input wire logic [63:0] i_wdata,
  output logic o_ack,
  output logic [63:0] o_rdata
);
  logic [7:0] mem [int];
  int rd_q [$];
  int wr_cnt = 0;
  int wait_n = 0;
  int pat = 0;
  initial begin
    o_ack = 1'b0;
    o_rdata = 64'h0;
  end
  ////////////////////////////////////////////////////////////////////
  // latency cycles through 0,3,2,1; an idle data bus toggles
  always @(negedge i_clock) begin
    o_ack <= 1'b0;
    o_rdata <= ~o_rdata;
    if (i_req && !o_ack) begin
      if (wait_n < (pat * 3) % 4) begin
        wait_n++;
      end else begin
        wait_n = 0;
        pat++;
        o_ack <= 1'b1;
        if (i_we) begin
          wr_cnt++;
          for (int b = 0; b < 8; b++) begin
            if (i_be[b]) mem[int'(i_addr) + b] = i_wdata[8*b+:8];
          end
        end else begin
          rd_q.push_back(int'(i_addr));
          for (int b = 0; b < 8; b++) begin
            o_rdata[8*b+:8] <= mem.exists(int'(i_addr) + b) ? mem[int'(i_addr) + b] :
              8'(i_addr + 29'(b)) ^ 8'((i_addr + 29'(b)) >> 8) ^ 8'h5A;
          end
        end
      end
    end
  end
endmodule : ocm_mem_model

/* File: test/tb_operand_cache_controller.sv */
// tb_operand_cache_controller: self-checking bench for the operand data cache
// assumes ocm_mem_model answers the memory bus; the bench plays the cpu side
`timescale 1ns/1ps
module tb_operand_cache_controller;
  import ocm_pkg::*;
  logic i_clock = 0, i_reset = 1, i_manual_reset = 0, i_ctrl_wr = 0, i_cpu_req = 0;
  logic i_cpu_we = 0, i_area_cacheable = 1, i_priv_region = 1, i_xlate_on = 0;
  logic i_page_cacheable = 1, i_page_wthru = 0, i_mem_ack;
  logic o_cpu_ready, o_cpu_rvalid, o_mem_req, o_mem_we;
  logic [31:0] i_ctrl_wdata = 0, o_ctrl_word, i_cpu_ea = 0, v, seed = 32'hC4AD;
  logic [28:0] i_cpu_pa = 0, o_mem_addr, pa;
  logic [63:0] i_cpu_wdata = 0, o_cpu_rdata, o_mem_wdata, i_mem_rdata;
  logic [7:0] o_mem_be;
  logic [7:0] cv [int];
  logic [1:0] i_cpu_size = 0, sz;
  int miscompares = 0, check_count = 0, r0, w0, w1, k;
  ocm_cache dut (.i_clock, .i_reset, .i_manual_reset, .i_ctrl_wr, .i_ctrl_wdata, .o_ctrl_word,
    .i_cpu_req, .i_cpu_we, .i_cpu_size, .i_cpu_ea, .i_cpu_pa, .i_cpu_wdata, .i_area_cacheable,
    .i_priv_region, .i_xlate_on, .i_page_cacheable, .i_page_wthru, .o_cpu_ready, .o_cpu_rvalid,
    .o_cpu_rdata, .o_mem_req, .o_mem_we, .o_mem_addr, .o_mem_be, .o_mem_wdata, .i_mem_ack,
    .i_mem_rdata);
  ocm_mem_model mem (.i_clock, .i_req(o_mem_req), .i_we(o_mem_we), .i_addr(o_mem_addr),
    .i_be(o_mem_be), .i_wdata(o_mem_wdata), .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));
  ////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [63:0] exp_load(input logic [1:0] s, input logic [28:0] a);
    logic [63:0] r;
    int b;
    r = 64'h0;
    for (int i = 0; i < (1 << s); i++) begin
      b = int'(a) + i;
      r[8*i+:8] = cv.exists(b) ? cv[b] : 8'(b) ^ 8'(b >> 8) ^ 8'h5A;
    end
    return r;
  endfunction : exp_load
  function automatic logic [28:0] ad(input int t, input int ix, input int off);
    return {15'(t), 9'(ix), 5'(off)};
  endfunction : ad
  ////////////////////////////////////////////////////////////////////
  task automatic op(input logic we, input logic [1:0] s, input logic [28:0] a,
                    input logic [63:0] wd);
    @(negedge i_clock);
    i_cpu_req = 1'b1;
    i_cpu_we = we;
    i_cpu_size = s;
    i_cpu_ea = {3'h0, a};
    i_cpu_pa = a;
    i_cpu_wdata = wd;
    k = 0;
    while (o_cpu_ready !== 1'b1 && k < 500) begin
      @(negedge i_clock);
      k++;
    end
    @(posedge i_clock);
    k = 0;
    forever begin
      @(negedge i_clock);
      i_cpu_req = 1'b0;
      k++;
      if ((we ? o_cpu_ready : o_cpu_rvalid) === 1'b1 || k > 500) break;
    end
    if (we) begin
      for (int i = 0; i < (1 << s); i++) cv[int'(a) + i] = wd[8*i+:8];
    end else begin
      check("load data", o_cpu_rdata, exp_load(s, a));
    end
    while (o_cpu_ready !== 1'b1 && k < 1000) begin
      @(negedge i_clock);
      k++;
    end
    if (k > 500) miscompares++;
  endtask : op
  task automatic xop(input logic we, input logic [1:0] s, input logic [28:0] a,
                     input int nr, input int nw);
    r0 = mem.rd_q.size();
    w0 = mem.wr_cnt;
    op(we, s, a, {rnd(), rnd()});
    check("memory reads", 64'(mem.rd_q.size() - r0), 64'(nr));
    if (nw >= 0) check("memory writes", 64'(mem.wr_cnt - w0), 64'(nw));
  endtask : xop
  task automatic ctl(input logic [31:0] c);
    @(negedge i_clock);
    i_ctrl_wr = 1'b1;
    i_ctrl_wdata = c;
    @(negedge i_clock);
    i_ctrl_wr = 1'b0;
    @(negedge i_clock);
  endtask : ctl
  ////////////////////////////////////////////////////////////////////
  initial begin
    forever #5 i_clock = ~i_clock;
  end
  initial begin
    #500000;
    miscompares++;
    give_verdict();
  end
  initial begin
    repeat (6) @(negedge i_clock);
    i_reset = 1'b0;
    @(negedge i_clock);
    check("idle after reset", {o_cpu_ready, o_cpu_rvalid, o_mem_req}, 3'h4);
    ctl(32'hFFFF_FFFF);
    check("control readback", o_ctrl_word, 32'h8000_0007);
    $display("test control done");
    ctl(32'h5);
    xop(0, SZ_QUAD, ad(1, 3, 24), 4, 0);
    check("critical first", 64'(mem.rd_q[r0]), 64'(ad(1, 3, 24)));
    check("wrap order", 64'(mem.rd_q[r0 + 1]), 64'(ad(1, 3, 0)));
    xop(0, SZ_BYTE, ad(1, 3, 17), 0, 0);
    check("hit latency", 64'(k), 64'h2);
    xop(1, SZ_WORD, ad(1, 3, 6), 0, 0);
    check("store latency", 64'(k), 64'h2);
    xop(0, SZ_LONG, ad(1, 3, 4), 0, 0);
    xop(1, SZ_LONG, ad(2, 3, 16), 4, 4);
    xop(0, SZ_QUAD, ad(2, 3, 16), 0, 0);
    xop(0, SZ_QUAD, ad(3, 3, 0), 4, 4);
    ctl(32'h0);
    xop(0, SZ_QUAD, ad(1, 3, 0), 1, 0);
    xop(0, SZ_LONG, ad(2, 3, 16), 1, 0);
    $display("test copy-back done");
    i_priv_region = 1'b0;
    ctl(32'h3);
    xop(0, SZ_QUAD, ad(1, 5, 0), 4, 0);
    w1 = mem.wr_cnt;
    xop(1, SZ_BYTE, ad(1, 5, 3), 0, -1);
    check("buffered store latency", 64'(k), 64'h2);
    xop(0, SZ_QUAD, ad(2, 5, 0), 4, -1);
    check("write-through writes", 64'(mem.wr_cnt - w1), 64'h1);
    xop(1, SZ_LONG, ad(3, 7, 4), 0, -1);
    xop(0, SZ_LONG, ad(3, 7, 4), 4, -1);
    ctl(32'hB);
    check("invalidate reads zero", o_ctrl_word, 32'h3);
    xop(0, SZ_QUAD, ad(2, 5, 0), 4, 0);
    i_manual_reset = 1'b1;
    @(negedge i_clock);
    i_manual_reset = 1'b0;
    check("control after manual reset", o_ctrl_word, 32'h0);
    ctl(32'h3);
    xop(0, SZ_QUAD, ad(2, 5, 0), 0, 0);
    $display("test write-through done");
    i_priv_region = 1'b1;
    ctl(32'h8000_0005);
    xop(0, SZ_QUAD, ad(1, 9, 0), 4, 0);
    xop(0, SZ_QUAD, ad(2, 9, 0), 4, 0);
    xop(0, SZ_QUAD, ad(1, 9, 0), 0, 0);
    xop(0, SZ_QUAD, ad(3, 9, 0), 4, 0);
    xop(0, SZ_QUAD, ad(1, 9, 0), 0, 0);
    xop(0, SZ_QUAD, ad(2, 9, 0), 4, 0);
    i_xlate_on = 1'b1;
    i_page_cacheable = 1'b0;
    xop(0, SZ_QUAD, ad(1, 9, 0), 1, 0);
    i_page_cacheable = 1'b1;
    $display("test two-way done");
    ctl(32'h8000_0007);
    repeat (300) begin
      v = rnd();
      i_xlate_on = v[0];
      i_page_wthru = v[1];
      i_priv_region = v[2];
      sz = v[4:3];
      pa = ad(int'(v[6:5]) + 1, int'(v[8:7]), int'(v[13:9]) & ~((1 << sz) - 1));
      op(v[14], sz, pa, {rnd(), rnd()});
    end
    $display("test random done");
    give_verdict();
  end
endmodule : tb_operand_cache_controller
